/* verilog/vga_sequencer_plane_control.sv */
// Purpose: sequencer registers, clocking, font addressing and plane control
// Assumes: cpu access and fetch inputs come from logic on clk_sys
// Notes: indices 0 and above 4 are handed to the extension register port
// What this block does
// - full bandwidth stops refresh, syncs keep running
// - full bandwidth holds blanking output asserted
// - shifter load every 1, 2 or 4 chars
// - dot clock is video clock, optionally halved
// - char clock is eight or nine dots
// - plane mask gates planes in modes 0-3, except mode 1 with gcExtPixelBit set
// - mask becomes per-pixel enable in extended modes
// - same mask write-protects block-transfer pixels
// - secondary map bits decode to font offset
// - primary map bits decode the same way
// - char plane 0, attribute 1, font 2
// - attribute bit 3 picks font when enabled
// - font address is map, code, row
// - chain-4 selects plane by low address bits
// - chain-4 ignores read-plane selection on reads
// - odd/even sends even/odd addresses to plane pairs
// - extended-memory clear limits memory to 64K
// - index port selects register for data port
`timescale 1ns/1ps
`default_nettype none
module vga_sequencer_plane_control #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // indexed i/o port pair
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic ioDataPort,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // extension registers outside this block
  output logic extWrite,
  output logic extRead,
  output logic [4:0] extIndex,
  output logic [7:0] extWrData,
  input wire logic [7:0] extRdData,
  // clocking and display
  input wire logic videoClockIn,
  input wire logic displayBlankIn_n,
  output logic blank_n,
  output logic screenFetchEn,
  output logic dotTick,
  output logic charTick,
  output logic loadTick,
  // cpu memory access
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [2:0] cpuWriteMode,
  input wire logic gcExtPixelBit,
  input wire logic gcPlaneInterleaveBit,
  input wire logic [1:0] readPlaneSelect,
  output logic [3:0] planeWriteEn,
  output logic [7:0] pixelWriteEn,
  output logic pixelMaskMode,
  output logic [7:0] bltWriteProtect,
  output logic [1:0] readPlane,
  output logic [ADDR_W-1:0] memAddr,
  // text fetch
  input wire vsq_pkg::vsq_fetch_t fetchPhase,
  input wire logic [7:0] charCode,
  input wire logic [7:0] attrByte,
  input wire logic [4:0] rowIndex,
  output logic [1:0] fetchPlane,
  output logic [15:0] fontAddr,
  output logic fontIntensity,
  output logic fontSecondary
);
  logic rstMeta_r, rstSync_n;
  logic [4:0] index_r, indexNxt;
  logic [7:0] clocking_r, clockingNxt;
  logic [7:0] planeMask_r, planeMaskNxt;
  logic [7:0] fontMap_r, fontMapNxt;
  logic [7:0] memMode_r, memModeNxt;
  logic [7:0] rdNxt;
  logic extWriteNxt, dataWrite, dataRead, isExt;
  vsq_pkg::vsq_clk_cfg_t clkCfg;
  vsq_pkg::vsq_mem_cfg_t memCfg;
  logic [2:0] priMap, secMap, useMap;
  logic dualFont, useSec;
  logic [1:0] planeNxt;
  logic [15:0] fontAddrNxt;
  logic blankNxt;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // register file: index port then data port
  always_comb begin
    dataWrite = ioWrite && ioDataPort;
    dataRead = ioRead && ioDataPort;
    isExt = (index_r == 5'h00) || (index_r > vsq_pkg::IDX_MEM_MODE);
    indexNxt = index_r;
    clockingNxt = clocking_r;
    planeMaskNxt = planeMask_r;
    fontMapNxt = fontMap_r;
    memModeNxt = memMode_r;
    extWriteNxt = dataWrite && isExt;
    if (ioWrite && !ioDataPort) begin
      indexNxt = ioWrData[4:0];
    end
    if (dataWrite) begin
      case (index_r)
        vsq_pkg::IDX_CLOCKING: clockingNxt = ioWrData & vsq_pkg::MASK_CLOCKING;
        vsq_pkg::IDX_PLANE_MASK: planeMaskNxt = ioWrData & vsq_pkg::MASK_PLANE;
        vsq_pkg::IDX_FONT_MAP: fontMapNxt = ioWrData & vsq_pkg::MASK_FONT;
        vsq_pkg::IDX_MEM_MODE: memModeNxt = ioWrData & vsq_pkg::MASK_MEM;
        default: ;
      endcase
    end
  end

  // read answer one cycle after the read strobe
  always_comb begin
    rdNxt = ioRdData;
    if (ioRead && !ioDataPort) begin
      rdNxt = {3'h0, index_r};
    end else if (dataRead) begin
      case (index_r)
        vsq_pkg::IDX_CLOCKING: rdNxt = clocking_r;
        vsq_pkg::IDX_PLANE_MASK: rdNxt = planeMask_r;
        vsq_pkg::IDX_FONT_MAP: rdNxt = fontMap_r;
        vsq_pkg::IDX_MEM_MODE: rdNxt = memMode_r;
        default: rdNxt = extRdData;
      endcase
    end
  end

  // ext read is a handshake and may stay combinational
  assign extRead = dataRead && isExt;
  assign extIndex = index_r;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      index_r <= 5'h00;
      clocking_r <= vsq_pkg::RST_CLOCKING;
      planeMask_r <= vsq_pkg::RST_PLANE;
      fontMap_r <= vsq_pkg::RST_FONT;
      memMode_r <= vsq_pkg::RST_MEM;
      ioRdData <= 8'h00;
      extWrite <= 1'b0;
      extWrData <= 8'h00;
    end else begin
      index_r <= indexNxt;
      clocking_r <= clockingNxt;
      planeMask_r <= planeMaskNxt;
      fontMap_r <= fontMapNxt;
      memMode_r <= memModeNxt;
      ioRdData <= rdNxt;
      extWrite <= extWriteNxt;
      extWrData <= dataWrite ? ioWrData : extWrData;
    end
  end

  // decoded configuration fields
  always_comb begin
    clkCfg.fullBw = clocking_r[vsq_pkg::CLK_FULL_BW];
    clkCfg.load32 = clocking_r[vsq_pkg::CLK_LOAD32];
    clkCfg.dotDiv2 = clocking_r[vsq_pkg::CLK_DOT_DIV2];
    clkCfg.load16 = clocking_r[vsq_pkg::CLK_LOAD16];
    clkCfg.dot8 = clocking_r[vsq_pkg::CLK_DOT8];
    memCfg.chain4 = memMode_r[vsq_pkg::MEM_CHAIN4];
    memCfg.oddEvenOff = memMode_r[vsq_pkg::MEM_ODD_EVEN];
    memCfg.extMem = memMode_r[vsq_pkg::MEM_EXTENDED];
  end

  // font map decode and text fetch addressing
  always_comb begin
    secMap = {fontMap_r[vsq_pkg::FONT_SEC_HI],
              fontMap_r[vsq_pkg::FONT_SEC_LO+1 -: 2]};
    priMap = {fontMap_r[vsq_pkg::FONT_PRI_HI],
              fontMap_r[vsq_pkg::FONT_PRI_LO+1 -: 2]};
    dualFont = (priMap != secMap) && memCfg.extMem;
    useSec = dualFont && attrByte[vsq_pkg::ATTR_FONT_BIT];
    useMap = useSec ? secMap : priMap;
    // map 4 sits at 8K, so the map msb lands on address bit 13
    fontAddrNxt = {useMap[1:0], useMap[2], charCode, rowIndex};
    case (fetchPhase)
      vsq_pkg::VSQ_FETCH_CHAR: planeNxt = vsq_pkg::PLANE_CHAR;
      vsq_pkg::VSQ_FETCH_ATTR: planeNxt = vsq_pkg::PLANE_ATTR;
      vsq_pkg::VSQ_FETCH_FONT: planeNxt = vsq_pkg::PLANE_FONT;
      default: planeNxt = vsq_pkg::PLANE_CHAR;
    endcase
    blankNxt = clkCfg.fullBw ? 1'b0 : displayBlankIn_n;
  end

  // text fetch and blanking outputs
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fetchPlane <= vsq_pkg::PLANE_CHAR;
      fontAddr <= 16'h0000;
      fontIntensity <= 1'b0;
      fontSecondary <= 1'b0;
      blank_n <= 1'b0;
      screenFetchEn <= 1'b0;
      bltWriteProtect <= 8'h00;
    end else begin
      fetchPlane <= planeNxt;
      fontAddr <= fontAddrNxt;
      fontIntensity <= dualFont ? 1'b0 : attrByte[vsq_pkg::ATTR_FONT_BIT];
      fontSecondary <= useSec;
      blank_n <= blankNxt;
      screenFetchEn <= !clkCfg.fullBw;
      bltWriteProtect <= planeMask_r;
    end
  end

  vsq_clock_div u_clock_div (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .videoClockIn(videoClockIn),
    .cfg(clkCfg),
    .dotTick(dotTick),
    .charTick(charTick),
    .loadTick(loadTick)
  );

  vsq_plane_map #(
    .ADDR_W(ADDR_W)
  ) u_plane_map (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .memCfg(memCfg),
    .planeMask(planeMask_r),
    .cpuAddr(cpuAddr),
    .cpuWriteMode(cpuWriteMode),
    .gcExtPixelBit(gcExtPixelBit),
    .gcPlaneInterleaveBit(gcPlaneInterleaveBit),
    .readPlaneSelect(readPlaneSelect),
    .planeWriteEn(planeWriteEn),
    .pixelWriteEn(pixelWriteEn),
    .pixelMaskMode(pixelMaskMode),
    .readPlane(readPlane),
    .memAddr(memAddr)
  );

  a_blank_forced: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    clkCfg.fullBw [*2] |-> !blank_n) else $error("blank not held in full bandwidth");
  a_refresh_halt: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    clkCfg.fullBw |=> !screenFetchEn)
    else $error("screen fetch not halted");
  a_font_address: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    1'b1 |=> fontAddr[12:0] == {$past(charCode), $past(rowIndex)})
    else $error("font address code or row");
  a_font_map: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !dualFont |=> fontAddr[15:13] == {$past(priMap[1:0]), $past(priMap[2])} && !fontSecondary)
    else $error("primary font map");
  a_index_read: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dataRead && index_r == vsq_pkg::IDX_CLOCKING |=> ioRdData == $past(clocking_r))
    else $error("clocking readback");
  a_blt_protect: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dataWrite && index_r == vsq_pkg::IDX_PLANE_MASK |-> ##2 bltWriteProtect == $past(ioWrData, 2))
    else $error("blt write protect");
endmodule : vga_sequencer_plane_control
`default_nettype wire

/* verilog/vsq_pkg.sv */
// Purpose: shared constants and types for the sequencer plane control block
// Assumes: registers are 8 bits wide, reached through an index/data port pair
// Notes: bits that are reserved in a register are masked off and read as zero
package vsq_pkg;
  // register indices seen through the data port
  localparam logic [4:0] IDX_CLOCKING = 5'h01;
  localparam logic [4:0] IDX_PLANE_MASK = 5'h02;
  localparam logic [4:0] IDX_FONT_MAP = 5'h03;
  localparam logic [4:0] IDX_MEM_MODE = 5'h04;
  // implemented bits per register
  localparam logic [7:0] MASK_CLOCKING = 8'h3d;
  localparam logic [7:0] MASK_PLANE = 8'hff;
  localparam logic [7:0] MASK_FONT = 8'h3f;
  localparam logic [7:0] MASK_MEM = 8'h0e;
  localparam logic [7:0] RST_CLOCKING = 8'h00;
  localparam logic [7:0] RST_PLANE = 8'h00;
  localparam logic [7:0] RST_FONT = 8'h00;
  localparam logic [7:0] RST_MEM = 8'h00;
  // field positions
  localparam int CLK_FULL_BW = 5;
  localparam int CLK_LOAD32 = 4;
  localparam int CLK_DOT_DIV2 = 3;
  localparam int CLK_LOAD16 = 2;
  localparam int CLK_DOT8 = 0;
  localparam int MEM_CHAIN4 = 3;
  localparam int MEM_ODD_EVEN = 2;
  localparam int MEM_EXTENDED = 1;
  localparam int FONT_SEC_HI = 5;
  localparam int FONT_PRI_HI = 4;
  localparam int FONT_SEC_LO = 2;
  localparam int FONT_PRI_LO = 0;
  localparam int ATTR_FONT_BIT = 3;
  // dot and load counting
  localparam logic [3:0] DOT_LAST_NARROW = 4'h7;
  localparam logic [3:0] DOT_LAST_WIDE = 4'h8;
  localparam logic [1:0] LOAD_LAST_1 = 2'h0;
  localparam logic [1:0] LOAD_LAST_2 = 2'h1;
  localparam logic [1:0] LOAD_LAST_4 = 2'h3;
  // plane selection
  localparam int MEM64K_AW = 16;
  localparam logic [3:0] PLANES_ALL = 4'hf;
  localparam logic [3:0] PLANES_EVEN = 4'h5;
  localparam logic [3:0] PLANES_ODD = 4'ha;
  localparam logic [1:0] PLANE_CHAR = 2'h0;
  localparam logic [1:0] PLANE_ATTR = 2'h1;
  localparam logic [1:0] PLANE_FONT = 2'h2;
  localparam logic [2:0] WM_ONE = 3'h1;
  localparam logic [2:0] WM_EXT4 = 3'h4;
  localparam logic [2:0] WM_EXT5 = 3'h5;
  typedef struct packed {
    logic fullBw;
    logic load32;
    logic dotDiv2;
    logic load16;
    logic dot8;
  } vsq_clk_cfg_t;
  typedef struct packed {
    logic chain4;
    logic oddEvenOff;
    logic extMem;
  } vsq_mem_cfg_t;
  typedef enum logic [1:0] {
    VSQ_FETCH_CHAR = 2'b00,
    VSQ_FETCH_ATTR = 2'b01,
    VSQ_FETCH_FONT = 2'b10
  } vsq_fetch_t;
endpackage : vsq_pkg

/* verilog/vsq_clock_div.sv */
// Purpose: dot, character and shifter-load ticks from the video clock pin
// Assumes: video clock is well below clk_sys/2, so each edge is seen
// Notes: ticks are one clk_sys cycle wide
`timescale 1ns/1ps
`default_nettype none
module vsq_clock_div (
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire logic videoClockIn,
  input wire vsq_pkg::vsq_clk_cfg_t cfg,
  output logic dotTick,
  output logic charTick,
  output logic loadTick
);
  logic syncA_r, syncB_r, syncC_r, level_r, levelNxt, videoTick;
  logic dotPhase_r, dotPhaseNxt, dotNxt, charNxt, loadNxt;
  logic [3:0] dotCnt_r, dotCntNxt, dotLast;
  logic [1:0] loadCnt_r, loadCntNxt, loadLast;

  // a change counts once the second and third stage agree
  always_comb begin
    levelNxt = (syncB_r == syncC_r) ? syncC_r : level_r;
    videoTick = levelNxt && !level_r;
    dotLast = cfg.dot8 ? vsq_pkg::DOT_LAST_NARROW : vsq_pkg::DOT_LAST_WIDE;
    loadLast = cfg.load32 ? vsq_pkg::LOAD_LAST_4 :
               (cfg.load16 ? vsq_pkg::LOAD_LAST_2 : vsq_pkg::LOAD_LAST_1);
    dotPhaseNxt = dotPhase_r;
    dotNxt = 1'b0;
    if (videoTick) begin
      dotPhaseNxt = cfg.dotDiv2 ? !dotPhase_r : 1'b0;
      dotNxt = !cfg.dotDiv2 || dotPhase_r;
    end
    dotCntNxt = dotCnt_r;
    charNxt = 1'b0;
    if (dotNxt) begin
      charNxt = (dotCnt_r >= dotLast);
      dotCntNxt = charNxt ? 4'h0 : dotCnt_r + 4'h1;
    end
    loadCntNxt = loadCnt_r;
    loadNxt = 1'b0;
    if (charNxt) begin
      loadNxt = (loadCnt_r >= loadLast) && !cfg.fullBw;
      loadCntNxt = (loadCnt_r >= loadLast) ? 2'h0 : loadCnt_r + 2'h1;
    end
  end

  // character ticks keep running in full bandwidth so syncs continue
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      syncC_r <= 1'b0;
      level_r <= 1'b0;
      dotPhase_r <= 1'b0;
      dotCnt_r <= 4'h0;
      loadCnt_r <= 2'h0;
      dotTick <= 1'b0;
      charTick <= 1'b0;
      loadTick <= 1'b0;
    end else begin
      syncA_r <= videoClockIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      level_r <= levelNxt;
      dotPhase_r <= dotPhaseNxt;
      dotCnt_r <= dotCntNxt;
      loadCnt_r <= loadCntNxt;
      dotTick <= dotNxt;
      charTick <= charNxt;
      loadTick <= loadNxt;
    end
  end

  a_dot_undivided: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    videoTick && !cfg.dotDiv2 |=> dotTick) else $error("dot tick missed");
  a_dot_halved: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dotTick && $past(cfg.dotDiv2) |-> $past(dotPhase_r)) else $error("dot not halved");
  a_char_width: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    charTick && $past(dotCnt_r) <= $past(dotLast) |-> $past(dotCnt_r) == $past(dotLast))
    else $error("wrong char width");
  a_load_halted: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    cfg.fullBw |=> !loadTick) else $error("load during full bandwidth");
  a_load_every4: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    loadTick && $past(cfg.load32) |-> $past(loadCnt_r) == 2'h3) else $error("load rate");
endmodule : vsq_clock_div
`default_nettype wire

/* verilog/vsq_plane_map.sv */
// Purpose: maps a cpu access onto planes, plane address and write enables
// Assumes: cpu access fields are stable in the cycle they are presented
// Notes: results are registered, one cycle after the access fields
`timescale 1ns/1ps
`default_nettype none
module vsq_plane_map #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire vsq_pkg::vsq_mem_cfg_t memCfg,
  input wire logic [7:0] planeMask,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [2:0] cpuWriteMode,
  input wire logic gcExtPixelBit,
  input wire logic gcPlaneInterleaveBit,
  input wire logic [1:0] readPlaneSelect,
  output logic [3:0] planeWriteEn,
  output logic [7:0] pixelWriteEn,
  output logic pixelMaskMode,
  output logic [1:0] readPlane,
  output logic [ADDR_W-1:0] memAddr
);
  localparam logic [ADDR_W-1:0] LIMIT64K = ADDR_W'({vsq_pkg::MEM64K_AW{1'b1}});
  logic [3:0] selNxt, weNxt;
  logic [1:0] rdNxt;
  logic [ADDR_W-1:0] addrNxt;
  logic pixNxt;

  if (ADDR_W < vsq_pkg::MEM64K_AW + 2) begin : g_bad_width
    $error("ADDR_W too small for plane mapping");
  end

  // chain-4 wins over both odd/even controls
  always_comb begin
    pixNxt = (cpuWriteMode == vsq_pkg::WM_EXT4) || (cpuWriteMode == vsq_pkg::WM_EXT5) ||
             ((cpuWriteMode == vsq_pkg::WM_ONE) && gcExtPixelBit);
    if (memCfg.chain4) begin
      selNxt = 4'h1 << cpuAddr[1:0];
      addrNxt = cpuAddr >> 2;
    end else if (!memCfg.oddEvenOff) begin
      selNxt = cpuAddr[0] ? vsq_pkg::PLANES_ODD : vsq_pkg::PLANES_EVEN;
      addrNxt = cpuAddr >> 1;
    end else begin
      selNxt = vsq_pkg::PLANES_ALL;
      addrNxt = cpuAddr;
    end
    // pixel mode reuses the mask bits, so planes are not masked there
    weNxt = selNxt & (pixNxt ? vsq_pkg::PLANES_ALL : planeMask[3:0]);
    if (!memCfg.extMem) begin
      addrNxt = addrNxt & LIMIT64K;
    end
    // reads follow the graphics-side odd/even bit, kept inverse by software
    if (memCfg.chain4) begin
      rdNxt = cpuAddr[1:0];
    end else if (gcPlaneInterleaveBit) begin
      rdNxt = {readPlaneSelect[1], cpuAddr[0]};
    end else begin
      rdNxt = readPlaneSelect;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      planeWriteEn <= 4'h0;
      pixelWriteEn <= 8'h00;
      pixelMaskMode <= 1'b0;
      readPlane <= 2'h0;
      memAddr <= '0;
    end else begin
      planeWriteEn <= weNxt;
      pixelWriteEn <= pixNxt ? planeMask : 8'h00;
      pixelMaskMode <= pixNxt;
      readPlane <= rdNxt;
      memAddr <= addrNxt;
    end
  end

  a_chain4_read: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    memCfg.chain4 |=> readPlane == $past(cpuAddr[1:0])) else $error("chain-4 read plane");
  a_oddeven_even: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !memCfg.chain4 && !memCfg.oddEvenOff && !cpuAddr[0] && !pixNxt
    |=> planeWriteEn == ($past(planeMask[3:0]) & 4'h5)) else $error("odd/even planes");
  a_mem_limit: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !memCfg.extMem |=> memAddr[ADDR_W-1:16] == '0) else $error("64K limit broken");
endmodule : vsq_plane_map
`default_nettype wire

/* tb/vga_sequencer_plane_control_tb.sv */
// Purpose: self-checking bench for the sequencer plane control block
// Assumes: video clock pin toggles every 4 clk_sys cycles, a period of 8 cycles
// Notes: all inputs move on the falling edge; outputs are sampled there too
`timescale 1ns/1ps
`default_nettype none
module vga_sequencer_plane_control_tb;
  logic clk_sys, rst_n, ioWrite, ioRead, ioDataPort, displayBlankIn_n;
  logic videoClockIn = 1'b0;
  logic [1:0] vcnt = 2'h0;
  logic [7:0] ioWrData, ioRdData, extWrData, extRdData, pixelWriteEn, bltWriteProtect;
  logic [7:0] charCode, attrByte;
  logic extWrite, extRead, blank_n, screenFetchEn, dotTick, charTick, loadTick;
  logic pixelMaskMode, gcExtPixelBit, gcPlaneInterleaveBit, fontIntensity, fontSecondary;
  logic [4:0] extIndex, rowIndex;
  logic [21:0] cpuAddr, memAddr;
  logic [2:0] cpuWriteMode;
  logic [1:0] readPlaneSelect, readPlane, fetchPlane;
  logic [3:0] planeWriteEn;
  logic [15:0] fontAddr;
  vsq_pkg::vsq_fetch_t fetchPhase;
  int miscompares, checks, n;
  int offK [8] = '{0, 16, 32, 48, 8, 24, 40, 56};
  logic [7:0] cfgV [8] = '{8'h01, 8'h00, 8'h09, 8'h08, 8'h01, 8'h05, 8'h11, 8'h15};
  int selV [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
  int expV [8] = '{64, 72, 128, 144, 64, 128, 256, 256};
  logic [2:0] wmV [4] = '{3'h4, 3'h5, 3'h1, 3'h1};

  vga_sequencer_plane_control #(.ADDR_W(22)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioDataPort(ioDataPort), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .extWrite(extWrite), .extRead(extRead), .extIndex(extIndex),
    .extWrData(extWrData), .extRdData(extRdData), .videoClockIn(videoClockIn),
    .displayBlankIn_n(displayBlankIn_n), .blank_n(blank_n), .screenFetchEn(screenFetchEn),
    .dotTick(dotTick), .charTick(charTick), .loadTick(loadTick), .cpuAddr(cpuAddr),
    .cpuWriteMode(cpuWriteMode), .gcExtPixelBit(gcExtPixelBit),
    .gcPlaneInterleaveBit(gcPlaneInterleaveBit), .readPlaneSelect(readPlaneSelect),
    .planeWriteEn(planeWriteEn), .pixelWriteEn(pixelWriteEn), .pixelMaskMode(pixelMaskMode),
    .bltWriteProtect(bltWriteProtect), .readPlane(readPlane), .memAddr(memAddr),
    .fetchPhase(fetchPhase), .charCode(charCode), .attrByte(attrByte), .rowIndex(rowIndex),
    .fetchPlane(fetchPlane), .fontAddr(fontAddr), .fontIntensity(fontIntensity),
    .fontSecondary(fontSecondary));

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // video clock pin, derived from clk_sys so tick spacing is exact
  always @(negedge clk_sys) begin
    vcnt <= vcnt + 2'h1;
    if (vcnt == 2'h3) videoClockIn <= ~videoClockIn;
  end

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one port write; the strobe drops a full cycle before any next request
  task automatic wr(input logic p, input logic [7:0] d);
    @(negedge clk_sys);
    ioDataPort <= p;
    ioWrData <= d;
    ioWrite <= 1'b1;
    @(negedge clk_sys);
    ioWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic p, input logic [7:0] exp, input string nm);
    @(negedge clk_sys);
    ioDataPort <= p;
    ioRead <= 1'b1;
    @(negedge clk_sys);
    ioRead <= 1'b0;
    chk(nm, {24'h0, exp}, {24'h0, ioRdData});
  endtask : rd

  task automatic setReg(input logic [7:0] i, input logic [7:0] v);
    wr(1'b0, i);
    wr(1'b1, v);
    repeat (3) @(negedge clk_sys);
  endtask : setReg

  // cycles between the second and third tick after a config change
  task automatic period(input int sel, input int exp);
    int k;
    k = 0;
    n = 0;
    while (k < 3 && n < 3000) begin
      @(negedge clk_sys);
      n++;
      if ((sel == 1 ? loadTick : sel == 2 ? dotTick : charTick) === 1'b1) begin
        k++;
        if (k == 2) n = 0;
      end
    end
    chk(sel == 1 ? "load period" : sel == 2 ? "dot period" : "char period", exp, n);
  endtask : period

  // cpu access: registers then fields, results one cycle later
  task automatic pm(input logic [7:0] mem, input logic [7:0] msk, input logic [2:0] wm,
      input logic ext, input logic gi, input logic [1:0] rps, input logic [21:0] a,
      input logic [3:0] ePl, input logic [7:0] ePix, input logic [1:0] eRp,
      input logic [21:0] eA);
    setReg(8'h04, mem);
    setReg(8'h02, msk);
    cpuWriteMode = wm;
    gcExtPixelBit = ext;
    gcPlaneInterleaveBit = gi;
    readPlaneSelect = rps;
    cpuAddr = a;
    @(negedge clk_sys);
    chk("planeWriteEn", ePl, planeWriteEn);
    chk("pixelWriteEn", ePix, pixelWriteEn);
    chk("pixelMaskMode", ePix != 8'h00, pixelMaskMode);
    chk("readPlane", eRp, readPlane);
    chk("memAddr", eA, memAddr);
    chk("bltWriteProtect", msk, bltWriteProtect);
  endtask : pm

  task automatic font(input logic [7:0] sel, input logic [7:0] mem, input logic [7:0] at,
      input int m, input logic eInt, input logic eSec);
    setReg(8'h03, sel);
    setReg(8'h04, mem);
    attrByte = at;
    @(negedge clk_sys);
    chk("fontAddr", offK[m] * 1024 + {charCode, rowIndex}, fontAddr);
    chk("fontIntensity", eInt, fontIntensity);
    chk("fontSecondary", eSec, fontSecondary);
  endtask : font

  // hang guard, well beyond the few thousand cycles the tests take
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    end_sim();
  end

  initial begin
    {rst_n, ioWrite, ioRead, ioDataPort, ioWrData} = '0;
    {cpuAddr, cpuWriteMode, gcExtPixelBit, gcPlaneInterleaveBit, readPlaneSelect} = '0;
    {charCode, attrByte, rowIndex, miscompares, checks} = '0;
    displayBlankIn_n = 1'b1;
    extRdData = 8'h3c;
    fetchPhase = vsq_pkg::VSQ_FETCH_CHAR;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // reset values, reserved bits and index readback
    for (int i = 1; i <= 4; i++) begin
      wr(1'b0, 8'(i));
      rd(1'b0, 8'(i), "index");
      rd(1'b1, 8'h00, "reset value");
      wr(1'b1, 8'hff);
      rd(1'b1, i == 1 ? 8'h3d : i == 2 ? 8'hff : i == 3 ? 8'h3f : 8'h0e, "masked");
    end
    wr(1'b0, 8'h07);
    wr(1'b1, 8'h5a);
    chk("extWrite", 1'b1, extWrite);
    @(negedge clk_sys);
    chk("extWrite end", 1'b0, extWrite);
    chk("extIndex", 5'h07, extIndex);
    chk("extWrData", 8'h5a, extWrData);
    // ext read strobe is combinational, so look a little after the input moves
    @(negedge clk_sys);
    ioRead <= 1'b1;
    #1 chk("extRead", 1'b1, extRead);
    @(negedge clk_sys);
    ioRead <= 1'b0;
    #1 chk("extRead end", 1'b0, extRead);
    chk("ext read", 8'h3c, ioRdData);
    $display("test registers done");
    // dot, char and load tick spacing for every divider setting
    for (int i = 0; i < 8; i++) begin
      setReg(8'h01, cfgV[i]);
      period(selV[i], expV[i]);
      period(2, cfgV[i][3] ? 16 : 8);
    end
    chk("blank_n", 1'b1, blank_n);
    chk("screenFetchEn", 1'b1, screenFetchEn);
    displayBlankIn_n = 1'b0;
    @(negedge clk_sys);
    chk("blank_n follow", 1'b0, blank_n);
    displayBlankIn_n = 1'b1;
    setReg(8'h01, 8'h21);
    chk("blank_n", 1'b0, blank_n);
    chk("screenFetchEn", 1'b0, screenFetchEn);
    period(0, 64);
    n = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (loadTick !== 1'b0) n++;
    end
    chk("loads in full bandwidth", 0, n);
    chk("blank_n held", 1'b0, blank_n);
    $display("test clocking done");
    // chain-4, odd/even, 64K limit, plain and pixel mask modes
    pm(8'h0e, 8'h0f, 3'h0, 0, 0, 2'h3, 22'h12346, 4'h4, 8'h00, 2'h2, 22'h048d1);
    pm(8'h02, 8'h0e, 3'h0, 0, 1, 2'h2, 22'h20001, 4'ha, 8'h00, 2'h3, 22'h10000);
    pm(8'h00, 8'h0f, 3'h0, 0, 1, 2'h2, 22'h30002, 4'h5, 8'h00, 2'h2, 22'h08001);
    pm(8'h06, 8'h05, 3'h2, 0, 0, 2'h1, 22'h3ffff, 4'h5, 8'h00, 2'h1, 22'h3ffff);
    for (int i = 0; i < 4; i++) begin
      pm(8'h06, 8'ha5, wmV[i], i < 3, 0, 2'h0, 22'h00010, i < 3 ? 4'hf : 4'h5,
         i < 3 ? 8'ha5 : 8'h00, 2'h0, 22'h00010);
    end
    $display("test plane mapping done");
    // text fetch planes and font addressing
    for (int p = 0; p < 3; p++) begin
      fetchPhase = vsq_pkg::vsq_fetch_t'(p);
      @(negedge clk_sys);
      chk("fetchPlane", p, fetchPlane);
    end
    rowIndex = 5'h0d;
    for (int m = 0; m < 8; m++) begin
      logic [2:0] s;
      s = 3'(7 - m);
      charCode = 8'(8'h41 + m);
      font({2'b00, s[2], 1'(m >> 2), s[1], s[0], 1'(m >> 1), 1'(m)}, 8'h06, 8'h00, m, 0, 0);
      font({2'b00, s[2], 1'(m >> 2), s[1], s[0], 1'(m >> 1), 1'(m)}, 8'h06, 8'h08, 7 - m, 0, 1);
      font({2'b00, s[2], 1'(m >> 2), s[1], s[0], 1'(m >> 1), 1'(m)}, 8'h04, 8'h08, m, 1, 0);
    end
    $display("test font done");
    end_sim();
  end
endmodule : vga_sequencer_plane_control_tb
`default_nettype wire
